// ---- test_touch_sensor_cmd_and_detect.sv ----
`timescale 1ns/1ps
`include "tsd_regs.vh"
module test_touch_sensor_cmd_and_detect;
	reg mclk_i;
	reg rst_i = 1'b1;
	reg sleep_i = 1'b0;
	reg ref_cmp_i = 1'b0;
	reg [7:0] sensor_state_reg_cmp_i = 8'h00;
	reg [7:0] up_mask = 8'h00;
	reg [2:0] cmp_chan = 3'h0;
	reg [2:0] cmp_cnt = 3'h0;
	integer failures = 0;
	integer total_checks = 0;
	integer cycles = 0;
	wire scl, sda_drv, sda_line, sda_o, sda_oe_n_o, int_n_o, int_over_bus_o, ref_start_o;
	wire asleep_o, vreg_en_o, fast_start_o;
	wire [2:0] chan_sel_o;
	wire [7:0] channel_detect_out_o, sensor_state_o, config_o, clock_set_o, mask_o;
	// Open drain with pull-up
	assign sda_line = sda_drv & (sda_oe_n_o | sda_o);
	tsd_ctl_model ctl (.scl_o(scl), .sda_drv_o(sda_drv), .sda_i(sda_line));
	tsd_core #(.STARTUP_CYC(16), .EVAL_MAX(64), .SAMP_BASE(8), .SAMP_STEP(8)) dut (
		.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n_o), .a0_i(1'b0), .sleep_i(sleep_i), .int_n_o(int_n_o),
		.int_over_bus_o(int_over_bus_o), .ref_cmp_i(ref_cmp_i), .sensor_state_reg_cmp_i(sensor_state_reg_cmp_i),
		.ref_start_o(ref_start_o), .chan_sel_o(chan_sel_o), .up_step_pulse_o(),
		.down_step_pulse_o(), .channel_detect_out_o(channel_detect_out_o),
		.asleep_o(asleep_o), .osc_en_o(), .vreg_en_o(vreg_en_o), .analog_en_o(),
		.fast_start_o(fast_start_o), .soft_reset_o(), .sensor_state_o(sensor_state_o),
		.config_o(config_o), .clock_set_o(clock_set_o), .mask_o(mask_o));
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	// ----------------
	// Comparators
	// ----------------
	// Trips three cycles after start, falls well before the next sample
	always @(posedge mclk_i) begin
		if (ref_start_o) begin
			cmp_chan <= chan_sel_o;
			cmp_cnt <= 3'h1;
		end else if (cmp_cnt != 3'h0) begin
			cmp_cnt <= cmp_cnt + 3'h1;
		end
		ref_cmp_i <= cmp_cnt >= 3'h2 && cmp_cnt < 3'h4 && up_mask[cmp_chan];
		sensor_state_reg_cmp_i <= (cmp_cnt >= 3'h2 && cmp_cnt < 3'h4 && !up_mask[cmp_chan])
			? (8'h01 << cmp_chan) : 8'h00;
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures = failures + 1;
			$display("[ERR] %0t timeout", $time);
			end_sim;
		end
	end
	task end_sim;
		begin
			if (failures == 0 && total_checks > 0) begin
				$display("ALL TESTS PASSED");
			end else begin
				$display("TESTS FAILED");
			end
			$finish;
		end
	endtask
	task chk(input [7:0] got, input [7:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task settle(input integer n);
		begin
			repeat (n) @(posedge mclk_i);
			#1;
		end
	endtask
	// Cycles between two successive sampling starts
	task gap(output integer g);
		begin
			g = 0;
			while (ref_start_o !== 1'b1) begin
				settle(1);
			end
			settle(1);
			while (ref_start_o !== 1'b1 && g < 2000) begin
				settle(1);
				g = g + 1;
			end
			g = g + 1;
		end
	endtask
	task cmd(input [7:0] op, input has_d, input [7:0] d);
		reg a0, a1, a2;
		begin
			a2 = 1'b0;
			ctl.start_bit;
			ctl.send_byte(8'h74, a0);
			ctl.send_byte(op, a1);
			if (has_d) begin
				ctl.send_byte(d, a2);
			end
			ctl.stop_bit;
			chk({5'h00, a0, a1, a2}, 8'h00);
			settle(4);
		end
	endtask
	task rdreg(input [7:0] op, input [7:0] exp);
		reg a0, a1, a2;
		reg [7:0] v;
		begin
			ctl.start_bit;
			ctl.send_byte(8'h74, a0);
			ctl.send_byte(op, a1);
			ctl.start_bit;
			ctl.send_byte(8'h75, a2);
			ctl.recv_byte(1'b1, v);
			ctl.stop_bit;
			chk(v, exp);
			chk({5'h00, a0, a1, a2}, 8'h00);
			settle(4);
		end
	endtask
	task chk_regs(input [7:0] c, input [7:0] k, input [7:0] m);
		begin
			chk(config_o, c);
			chk(clock_set_o, k);
			chk(mask_o, m);
		end
	endtask
	task wait_det(input [7:0] want);
		integer n;
		begin
			n = 0;
			while (channel_detect_out_o !== want && n < 12000) begin
				settle(1);
				n = n + 1;
			end
			settle(4);
			chk(channel_detect_out_o, want);
		end
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task t_regs;
		integer g0, g1;
		begin
			chk_regs(8'h00, 8'h0c, 8'hff);
			chk({6'h00, int_n_o, vreg_en_o}, 8'h03);
			gap(g0);
			cmd(`TSD_OP_WR_CONFIG, 1'b1, 8'h04);
			cmd(`TSD_OP_WR_CLOCK, 1'b1, 8'h00);
			gap(g1);
			// Step of 8 per unit, default field value 12
			chk(g0[7:0] - g1[7:0], 8'h60);
			cmd(`TSD_OP_WR_MASK, 1'b1, 8'hf3);
			cmd(8'h7e, 1'b0, 8'h00);
			chk_regs(8'h04, 8'h00, 8'hf3);
			chk({7'h00, vreg_en_o}, 8'h00);
			rdreg(`TSD_OP_RD_CONFIG, 8'h04);
			rdreg(`TSD_OP_RD_CLOCK, 8'h00);
			rdreg(`TSD_OP_RD_MASK, 8'hf3);
		end
	endtask
	task t_detect;
		reg a;
		reg [7:0] v0, v1;
		begin
			@(posedge mclk_i) up_mask <= 8'h01;
			wait_det(8'h01);
			chk(sensor_state_o, 8'h01);
			chk({7'h00, int_n_o}, 8'h00);
			ctl.start_bit;
			ctl.send_byte(8'h75, a);
			ctl.recv_byte(1'b0, v0);
			ctl.recv_byte(1'b1, v1);
			ctl.stop_bit;
			settle(4);
			chk({v0[6:0], a}, 8'h02);
			chk(v1, 8'h01);
			chk({7'h00, int_n_o}, 8'h01);
			@(posedge mclk_i) up_mask <= 8'h00;
			wait_det(8'h00);
			chk({7'h00, int_n_o}, 8'h00);
			cmd(`TSD_OP_CLEAR_INT, 1'b0, 8'h00);
			chk({7'h00, int_n_o}, 8'h01);
		end
	endtask
	task t_sleep;
		begin
			cmd(`TSD_OP_SLEEP, 1'b0, 8'h00);
			chk({7'h00, asleep_o}, 8'h01);
			@(posedge mclk_i) sleep_i <= 1'b1;
			settle(10);
			@(posedge mclk_i) sleep_i <= 1'b0;
			settle(10);
			chk({7'h00, asleep_o}, 8'h01);
			cmd(`TSD_OP_WR_MASK, 1'b1, 8'h3c);
			rdreg(`TSD_OP_RD_MASK, 8'h3c);
			cmd(`TSD_OP_WAKE, 1'b0, 8'h00);
			chk({7'h00, asleep_o}, 8'h00);
			@(posedge mclk_i) sleep_i <= 1'b1;
			settle(10);
			cmd(`TSD_OP_WAKE, 1'b0, 8'h00);
			chk({7'h00, asleep_o}, 8'h01);
			@(posedge mclk_i) sleep_i <= 1'b0;
			settle(10);
			chk({7'h00, asleep_o}, 8'h00);
		end
	endtask
	task t_softrst;
		begin
			cmd(`TSD_OP_INT_BUS, 1'b0, 8'h00);
			chk({7'h00, int_over_bus_o}, 8'h01);
			cmd(`TSD_OP_SOFT_RESET, 1'b0, 8'h00);
			chk_regs(8'h00, 8'h0c, 8'hff);
			chk({int_over_bus_o, vreg_en_o, 6'h00}, 8'h40);
			chk(sensor_state_o, 8'h00);
		end
	endtask
	initial begin
		settle(20);
		@(posedge mclk_i) rst_i <= 1'b0;
		settle(8);
		t_regs;
		t_detect;
		t_sleep;
		t_softrst;
		end_sim;
	end
endmodule // test_touch_sensor_cmd_and_detect

// ---- tsd_core.v ----
`timescale 1ns/1ps
`include "tsd_regs.vh"

// Notes on behaviour
// - Channels are evaluated in turn; reference starts at each channel's sample point, except masked channels when config bit 0 is set.
// - Reference tripping first gives an up pulse, sensor first a down pulse.
// - Per-channel run counter restarts whenever pulse direction changes.
// - Detect output sets only after 64 consecutive up pulses.
// - Detect outputs ANDed with the mask register stored in sensor state register; any change raises interrupt.
// - Sample rate is divided from the clock, adjustable by clock setting register.
// - Config, clock and mask each writable only by their own write command.
// - Soft reset opcode restores channels, registers and ends bus-interrupt mode.
// - Soft reset ends command sleep and reruns start-up with fast charging before sensing.
// - Clear-interrupt opcode releases the active-low interrupt output.
// - Config write takes one data byte; config read returns one byte.
// - Clock write takes one data byte; clock read returns one byte.
// - Mask write takes one data byte; mask read returns one byte.
// - Only power-on reset and soft reset exist.
// - Asleep powers down oscillator, regulator and analog blocks.
// - Asleep keeps registers and still serves bus commands.
// - Leaving sleep reruns full start-up with fast charging before sensing.
// - Sleep by opcode or high pin; awake only once command sleep is cleared by wake opcode or soft reset and the pin is low.
// - Command sleep and pin sleep are tracked and ended independently.
// - Read transaction returns sensor state and clears the interrupt.
// - Sensor state may be read repeatedly within one read transaction.
// - Sensor state bit n reflects channel n.
module tsd_core #(
	parameter STARTUP_CYC = `TSD_STARTUP_CYC,
	parameter EVAL_MAX = `TSD_EVAL_MAX,
	parameter SAMP_BASE = `TSD_SAMP_BASE,
	parameter SAMP_STEP = `TSD_SAMP_STEP
) (
	// Clock and power-on reset
	input wire mclk_i,
	input wire rst_i,
	// Serial bus
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_n_o,
	input wire a0_i,
	// Sleep and interrupt
	input wire sleep_i,
	output wire int_n_o,
	output wire int_over_bus_o,
	// Comparators and front end
	input wire ref_cmp_i,
	input wire [7:0] sensor_state_reg_cmp_i,
	output reg ref_start_o,
	output reg [2:0] chan_sel_o,
	output reg up_step_pulse_o,
	output reg down_step_pulse_o,
	output reg [7:0] channel_detect_out_o,
	// Power control
	output wire asleep_o,
	output wire osc_en_o,
	output wire vreg_en_o,
	output wire analog_en_o,
	output wire fast_start_o,
	output reg soft_reset_o,
	// Register contents
	output wire [7:0] sensor_state_o,
	output wire [7:0] config_o,
	output wire [7:0] clock_set_o,
	output wire [7:0] mask_o
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	reg [12:0] sy1_q, sy2_q, sy3_q, syn_q;
	// Stable once second and third stage agree
	always @(posedge mclk_i) begin
		if (rst_i) begin
			// Idle pin levels, so no false edge or sleep follows reset
			sy1_q <= 13'h1_800;
			sy2_q <= 13'h1_800;
			sy3_q <= 13'h1_800;
			syn_q <= 13'h1_800;
		end else begin
			sy1_q <= {scl_i, sda_i, a0_i, sleep_i, ref_cmp_i, sensor_state_reg_cmp_i};
			sy2_q <= sy1_q;
			sy3_q <= sy2_q;
			syn_q <= (sy2_q & sy3_q) | (syn_q & (sy2_q | sy3_q));
		end
	end
	wire scl_s = syn_q[12];
	wire sda_s = syn_q[11];
	wire a0_s = syn_q[10];
	wire pin_sleep_s = syn_q[9];
	wire ref_s = syn_q[8];
	wire [7:0] sen_s = syn_q[7:0];
	reg scl_p_q, sda_p_q;
	always @(posedge mclk_i) begin
		scl_p_q <= rst_i ? 1'b1 : scl_s;
		sda_p_q <= rst_i ? 1'b1 : sda_s;
	end
	wire scl_rise = scl_s & ~scl_p_q;
	wire scl_fall = ~scl_s & scl_p_q;
	wire bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

	// ----------------------------------------
	// Serial slave
	// ----------------------------------------
	localparam S_IDLE = 6'b00_0001;
	localparam S_ADDR = 6'b00_0010;
	localparam S_CMD = 6'b00_0100;
	localparam S_DATA = 6'b00_1000;
	localparam S_RD = 6'b01_0000;
	localparam S_RACK = 6'b10_0000;
	localparam RS_SENSOR_STATE_REG = 2'd0;
	localparam RS_CONF = 2'd1;
	localparam RS_CLK = 2'd2;
	localparam RS_MASK = 2'd3;

	reg [5:0] st_q, nxt_q;
	reg [3:0] bcnt_q;
	reg [7:0] sh_q, tx_q, op_q;
	reg ack_ph_q, drive_q, mack_q;
	reg cmd_stb_q, wr_stb_q, rd_stb_q;
	reg [7:0] cmd_q, wdat_q;
	reg [1:0] rd_sel_q;
	reg [7:0] sensor_state_reg_q, config_q, clock_q, mask_q;

	function [7:0] rd_mux;
		input [1:0] sel;
		input [7:0] s, c, k, m;
		begin
			case (sel)
				RS_CONF: rd_mux = c;
				RS_CLK: rd_mux = k;
				RS_MASK: rd_mux = m;
				default: rd_mux = s;
			endcase
		end
	endfunction
	wire [7:0] rd_byte = rd_mux(rd_sel_q, sensor_state_reg_q, config_q, clock_q, mask_q);

	// Bus runs in sleep too: this clock is the digital domain, not the sensing oscillator
	always @(posedge mclk_i) begin
		cmd_stb_q <= 1'b0;
		wr_stb_q <= 1'b0;
		rd_stb_q <= 1'b0;
		if (rst_i) begin
			st_q <= S_IDLE;
			nxt_q <= S_IDLE;
			bcnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			op_q <= 8'h00;
			ack_ph_q <= 1'b0;
			drive_q <= 1'b0;
			mack_q <= 1'b0;
			cmd_q <= 8'h00;
			wdat_q <= 8'h00;
		end else if (bus_start) begin
			st_q <= S_ADDR;
			bcnt_q <= 4'h0;
			ack_ph_q <= 1'b0;
			drive_q <= 1'b0;
		end else if (bus_stop) begin
			st_q <= S_IDLE;
			ack_ph_q <= 1'b0;
			drive_q <= 1'b0;
		end else if (scl_rise) begin
			if (st_q == S_RACK) begin
				mack_q <= ~sda_s;
			end else if (st_q == S_RD) begin
				bcnt_q <= bcnt_q + 4'h1;
			end else if (!ack_ph_q && st_q != S_IDLE) begin
				sh_q <= {sh_q[6:0], sda_s};
				bcnt_q <= bcnt_q + 4'h1;
			end
		end else if (scl_fall) begin
			if (ack_ph_q) begin
				ack_ph_q <= 1'b0;
				bcnt_q <= 4'h0;
				st_q <= nxt_q;
				drive_q <= (nxt_q == S_RD) ? ~tx_q[7] : 1'b0;
				tx_q <= {tx_q[6:0], 1'b0};
			end else case (st_q)
				S_ADDR: if (bcnt_q == 4'h8) begin
					if (sh_q[7:1] == {`TSD_ADDR_HI, a0_s}) begin
						ack_ph_q <= 1'b1;
						drive_q <= 1'b1;
						if (sh_q[0]) begin
							nxt_q <= S_RD;
							tx_q <= rd_byte;
							rd_stb_q <= 1'b1;
						end else begin
							nxt_q <= S_CMD;
						end
					end else begin
						st_q <= S_IDLE;
					end
				end
				S_CMD: if (bcnt_q == 4'h8) begin
					ack_ph_q <= 1'b1;
					drive_q <= 1'b1;
					op_q <= sh_q;
					cmd_q <= sh_q;
					cmd_stb_q <= 1'b1;
					// write opcodes take one data byte
					if (sh_q == `TSD_OP_WR_CONFIG || sh_q == `TSD_OP_WR_CLOCK ||
							sh_q == `TSD_OP_WR_MASK) begin
						nxt_q <= S_DATA;
					end else begin
						nxt_q <= S_IDLE;
					end
				end
				S_DATA: if (bcnt_q == 4'h8) begin
					ack_ph_q <= 1'b1;
					drive_q <= 1'b1;
					wdat_q <= sh_q;
					wr_stb_q <= 1'b1;
					nxt_q <= S_IDLE;
				end
				S_RD: begin
					if (bcnt_q == 4'h8) begin
						drive_q <= 1'b0;
						st_q <= S_RACK;
					end else begin
						drive_q <= ~tx_q[7];
						tx_q <= {tx_q[6:0], 1'b0};
					end
				end
				S_RACK: begin
					bcnt_q <= 4'h0;
					// master ack repeats the sensor byte
					if (mack_q) begin
						st_q <= S_RD;
						drive_q <= ~sensor_state_reg_q[7];
						tx_q <= {sensor_state_reg_q[6:0], 1'b0};
						rd_stb_q <= 1'b1;
					end else begin
						st_q <= S_IDLE;
					end
				end
				default: st_q <= S_IDLE;
			endcase
		end
	end
	assign sda_o = 1'b0;
	assign sda_oe_n_o = ~drive_q;

	// ----------------------------------------
	// Registers and modes
	// ----------------------------------------
	// soft reset applied one cycle after decode
	wire srst = rst_i | soft_reset_o;
	reg int_q, int_bus_q, cmd_sleep_q;
	wire [7:0] det_w;
	wire is_op_soft = cmd_stb_q && cmd_q == `TSD_OP_SOFT_RESET;

	always @(posedge mclk_i) begin
		soft_reset_o <= rst_i ? 1'b0 : is_op_soft;
	end

	always @(posedge mclk_i) begin
		if (srst) begin
			config_q <= `TSD_CONFIG_RST;
			clock_q <= `TSD_CLOCK_RST;
			mask_q <= `TSD_MASK_RST;
			sensor_state_reg_q <= `TSD_SENSOR_STATE_REG_RST;
			int_q <= 1'b0;
			int_bus_q <= 1'b0;
			cmd_sleep_q <= 1'b0;
			rd_sel_q <= RS_SENSOR_STATE_REG;
		end else begin
			sensor_state_reg_q <= det_w;
			// change raises interrupt; set beats clear
			if (det_w != sensor_state_reg_q) begin
				int_q <= 1'b1;
			// clear on command; cleared by read
			end else if ((cmd_stb_q && cmd_q == `TSD_OP_CLEAR_INT) ||
					(rd_stb_q && rd_sel_q == RS_SENSOR_STATE_REG)) begin
				int_q <= 1'b0;
			end
			if (rd_stb_q) begin
				rd_sel_q <= RS_SENSOR_STATE_REG;
			end
			if (cmd_stb_q) begin
				case (cmd_q)
					// sleep and wake opcodes; command flag only
					`TSD_OP_SLEEP: cmd_sleep_q <= 1'b1;
					`TSD_OP_WAKE: cmd_sleep_q <= 1'b0;
					// bus interrupt mode until soft reset
					`TSD_OP_INT_BUS: int_bus_q <= 1'b1;
					`TSD_OP_RD_CONFIG: rd_sel_q <= RS_CONF;
					`TSD_OP_RD_CLOCK: rd_sel_q <= RS_CLK;
					`TSD_OP_RD_MASK: rd_sel_q <= RS_MASK;
					default: rd_sel_q <= rd_sel_q;
				endcase
			end
			// each register only through its own write
			if (wr_stb_q) begin
				case (op_q)
					`TSD_OP_WR_CONFIG: config_q <= wdat_q;
					`TSD_OP_WR_CLOCK: clock_q <= wdat_q;
					`TSD_OP_WR_MASK: mask_q <= wdat_q;
					default: config_q <= config_q;
				endcase
			end
		end
	end
	assign int_n_o = ~int_q;
	assign int_over_bus_o = int_bus_q;
	assign sensor_state_o = sensor_state_reg_q;
	assign config_o = config_q;
	assign clock_set_o = clock_q;
	assign mask_o = mask_q;

	// ----------------------------------------
	// Sleep and start-up
	// ----------------------------------------
	// pin sleep follows the pin alone
	wire asleep = cmd_sleep_q | pin_sleep_s;
	localparam [15:0] STARTUP_N = STARTUP_CYC[15:0];
	reg [15:0] start_cnt_q;
	always @(posedge mclk_i) begin
		// start-up rerun after sleep and reset
		if (srst || asleep) begin
			start_cnt_q <= STARTUP_N;
		end else if (start_cnt_q != 16'h0000) begin
			start_cnt_q <= start_cnt_q - 16'h0001;
		end
	end
	// power down in sleep; registers untouched
	assign asleep_o = asleep;
	assign osc_en_o = ~asleep;
	assign vreg_en_o = ~asleep & ~config_q[2];
	assign analog_en_o = ~asleep;
	assign fast_start_o = ~asleep & (start_cnt_q != 16'h0000);

	// ----------------------------------------
	// Channel sequencer
	// ----------------------------------------
	localparam Q_WAIT = 3'b001;
	localparam Q_EVAL = 3'b010;
	localparam Q_NEXT = 3'b100;
	localparam [15:0] EVAL_N = EVAL_MAX[15:0];
	reg [2:0] sq_q;
	reg [15:0] div_q, ev_q;
	reg [6:0] run_q [0:7];
	reg dir_q [0:7];
	// divider period set by clock setting field
	wire [15:0] samp_per = SAMP_BASE[15:0] +
		SAMP_STEP[15:0] * {11'h000, clock_q[`TSD_CLK_FRQ_MSB:`TSD_CLK_FRQ_LSB]};
	wire run_ok = ~asleep & ~fast_start_o;
	wire chan_on = ~config_q[0] | mask_q[chan_sel_o];
	integer i;
	assign det_w = channel_detect_out_o & mask_q;

	always @(posedge mclk_i) begin
		up_step_pulse_o <= 1'b0;
		down_step_pulse_o <= 1'b0;
		ref_start_o <= 1'b0;
		if (srst) begin
			sq_q <= Q_WAIT;
			div_q <= 16'h0000;
			ev_q <= 16'h0000;
			chan_sel_o <= 3'h0;
			channel_detect_out_o <= 8'h00;
			for (i = 0; i < 8; i = i + 1) begin
				run_q[i] <= 7'h00;
				dir_q[i] <= 1'b0;
			end
		end else if (!run_ok) begin
			sq_q <= Q_WAIT;
			div_q <= 16'h0000;
		end else begin
			case (sq_q)
				Q_WAIT: begin
					div_q <= div_q + 16'h0001;
					// reference started at the sampling point
					if (div_q >= samp_per) begin
						div_q <= 16'h0000;
						ev_q <= 16'h0000;
						if (chan_on) begin
							ref_start_o <= 1'b1;
							sq_q <= Q_EVAL;
						end else begin
							sq_q <= Q_NEXT;
						end
					end
				end
				Q_EVAL: begin
					ev_q <= ev_q + 16'h0001;
					if (sen_s[chan_sel_o] || ref_s) begin
						sq_q <= Q_NEXT;
						up_step_pulse_o <= ~sen_s[chan_sel_o];
						down_step_pulse_o <= sen_s[chan_sel_o];
						if (dir_q[chan_sel_o] == sen_s[chan_sel_o]) begin
							run_q[chan_sel_o] <= 7'h01;
							dir_q[chan_sel_o] <= ~sen_s[chan_sel_o];
						end else if (run_q[chan_sel_o] != `TSD_RUN_LEN) begin
							run_q[chan_sel_o] <= run_q[chan_sel_o] + 7'h01;
							if (run_q[chan_sel_o] == `TSD_RUN_LEN - 7'h01) begin
								channel_detect_out_o[chan_sel_o] <= dir_q[chan_sel_o];
							end
						end
					end else if (ev_q >= EVAL_N) begin
						sq_q <= Q_NEXT;
					end
				end
				Q_NEXT: begin
					chan_sel_o <= chan_sel_o + 3'h1;
					sq_q <= Q_WAIT;
				end
				default: sq_q <= Q_WAIT;
			endcase
		end
	end

endmodule // tsd_core

// ---- tsd_core_asserts.sv ----
`timescale 1ns/1ps
module tsd_core_asserts (
	// Clock and reset
	input wire mclk_i,
	input wire rst_i,
	// Watched ports
	input wire sleep_i,
	input wire int_n_o,
	input wire int_over_bus_o,
	input wire up_step_pulse_o,
	input wire down_step_pulse_o,
	input wire [7:0] channel_detect_out_o,
	input wire asleep_o,
	input wire osc_en_o,
	input wire vreg_en_o,
	input wire analog_en_o,
	input wire fast_start_o,
	input wire soft_reset_o,
	input wire [7:0] sensor_state_o,
	input wire [7:0] config_o,
	input wire [7:0] clock_set_o,
	input wire [7:0] mask_o
);
	// ----------------
	// Up pulses seen
	// ----------------
	// Saturates, so a detect can never need fewer than the run length
	reg [7:0] ups_q;
	always @(posedge mclk_i) begin
		if (rst_i || soft_reset_o) begin
			ups_q <= 8'h00;
		end else if (up_step_pulse_o && ups_q != 8'hff) begin
			ups_q <= ups_q + 8'h01;
		end
	end
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	property p_sleep_off;
		asleep_o |-> !osc_en_o && !analog_en_o && !vreg_en_o;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("power on in sleep");
	property p_pin_sleep;
		$rose(sleep_i) |-> ##[1:6] asleep_o;
	endproperty
	a_pin_sleep: assert property (p_pin_sleep) else $error("pin sleep missed");
	property p_pin_hold;
		sleep_i [*8] |-> asleep_o;
	endproperty
	a_pin_hold: assert property (p_pin_hold) else $error("awake with pin high");
	property p_wake_start;
		$fell(asleep_o) |-> ##[0:2] fast_start_o;
	endproperty
	a_wake_start: assert property (p_wake_start) else $error("no start-up phase");
	property p_run64;
		$rose(|channel_detect_out_o) |-> ({1'b0, ups_q} + up_step_pulse_o) >= 9'h040;
	endproperty
	a_run64: assert property (p_run64) else $error("detect before run");
	property p_sensor_state_reg_map;
		!soft_reset_o && !$past(soft_reset_o)
			|-> sensor_state_o == ($past(channel_detect_out_o) & $past(mask_o));
	endproperty
	a_sensor_state_reg_map: assert property (p_sensor_state_reg_map) else $error("sensor state wrong");
	property p_int_set;
		$changed(sensor_state_o) && !$past(soft_reset_o) |-> ##[0:2] !int_n_o;
	endproperty
	a_int_set: assert property (p_int_set) else $error("no interrupt");
	property p_ibus_hold;
		$fell(int_over_bus_o) |-> $past(soft_reset_o) || $past(soft_reset_o, 2);
	endproperty
	a_ibus_hold: assert property (p_ibus_hold) else $error("bus mode lost");
	property p_soft_dflt;
		soft_reset_o |-> ##[1:2] (config_o == 8'h00 && clock_set_o == 8'h0c
			&& mask_o == 8'hff && !int_over_bus_o && channel_detect_out_o == 8'h00);
	endproperty
	a_soft_dflt: assert property (p_soft_dflt) else $error("soft reset values");
	property p_pulse_excl;
		up_step_pulse_o |-> !down_step_pulse_o && !asleep_o;
	endproperty
	a_pulse_excl: assert property (p_pulse_excl) else $error("bad step pulse");
endmodule // tsd_core_asserts

bind tsd_core tsd_core_asserts u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .sleep_i(sleep_i),
	.int_n_o(int_n_o), .int_over_bus_o(int_over_bus_o), .up_step_pulse_o(up_step_pulse_o),
	.down_step_pulse_o(down_step_pulse_o), .channel_detect_out_o(channel_detect_out_o),
	.asleep_o(asleep_o), .osc_en_o(osc_en_o), .vreg_en_o(vreg_en_o),
	.analog_en_o(analog_en_o), .fast_start_o(fast_start_o), .soft_reset_o(soft_reset_o),
	.sensor_state_o(sensor_state_o), .config_o(config_o), .clock_set_o(clock_set_o),
	.mask_o(mask_o));

// ---- tsd_ctl_model.sv ----
`timescale 1ns/1ps
module tsd_ctl_model (
	// Bus lines
	output reg scl_o,
	output reg sda_drv_o,
	input wire sda_i
);
	// Quarter of the 64 ns bus period
	localparam Q = 16;
	initial begin
		scl_o = 1'b1;
		sda_drv_o = 1'b1;
	end
	// Frame start
	task start_bit;
		begin
			sda_drv_o = 1'b1;
			#Q scl_o = 1'b1;
			#Q sda_drv_o = 1'b0;
			#Q scl_o = 1'b0;
			#Q;
		end
	endtask
	task stop_bit;
		begin
			sda_drv_o = 1'b0;
			#Q scl_o = 1'b1;
			#Q sda_drv_o = 1'b1;
			#Q;
		end
	endtask
	task put_bit(input b, output s);
		begin
			sda_drv_o = b;
			#Q scl_o = 1'b1;
			#Q s = sda_i;
			#Q scl_o = 1'b0;
			#Q;
		end
	endtask
	task send_byte(input [7:0] d, output ack);
		integer i;
		reg s;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				put_bit(d[i], s);
			end
			put_bit(1'b1, ack);
		end
	endtask
	task recv_byte(input last, output [7:0] d);
		integer i;
		reg s;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				put_bit(1'b1, s);
				d[i] = s;
			end
			put_bit(last, s);
		end
	endtask
endmodule // tsd_ctl_model

// ---- tsd_regs.vh ----
`ifndef TSD_REGS_VH
`define TSD_REGS_VH

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define TSD_OP_SOFT_RESET 8'h00
`define TSD_OP_CLEAR_INT 8'h03
`define TSD_OP_SLEEP 8'h05
`define TSD_OP_WAKE 8'h06
`define TSD_OP_WR_CONFIG 8'h30
`define TSD_OP_RD_CONFIG 8'h33
`define TSD_OP_WR_CLOCK 8'h35
`define TSD_OP_RD_CLOCK 8'h36
`define TSD_OP_WR_MASK 8'h39
`define TSD_OP_RD_MASK 8'h3A
`define TSD_OP_INT_BUS 8'h3C

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define TSD_CONFIG_RST 8'h00
`define TSD_SENSOR_STATE_REG_RST 8'h00
`define TSD_CLOCK_RST 8'h0C
`define TSD_MASK_RST 8'hFF
`define TSD_CLK_FRQ_MSB 4
`define TSD_CLK_FRQ_LSB 0

// ----------------------------------------
// Counts
// ----------------------------------------
`define TSD_RUN_LEN 7'h40
`define TSD_ADDR_HI 6'h1D
`define TSD_STARTUP_CYC 1024
`define TSD_SAMP_BASE 64
`define TSD_SAMP_STEP 8
`define TSD_EVAL_MAX 2048

`endif
